// ==== rtl/pbm_pkg.sv ====
// Constants and types shared by the basic management register bank.
package pbm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SOFT_RESET_NS = 1000;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] SOFT_RESET_LOAD = 16'(SOFT_RESET_CYCLES - 1);
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // ------------------------------------------------------------------
    // Management frame
    // ------------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HEADER_LAST = 5'h0C;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_CONTROL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_ID_HIGH = 5'h02;
    localparam logic [4:0] IDX_ID_LOW = 5'h03;
    localparam logic [4:0] IDX_ADVERTISE = 5'h04;
    localparam logic [4:0] IDX_PARTNER = 5'h05;
    localparam logic [4:0] IDX_EXPANSION = 5'h06;
    localparam logic [4:0] IDX_ENERGY_TIMING = 5'h10;
    localparam logic [4:0] IDX_MODE_CTL = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] IDX_SYMBOL_ERR = 5'h1A;
    localparam logic [4:0] IDX_SPECIAL_IND = 5'h1B;
    localparam logic [4:0] IDX_INT_SOURCE = 5'h1D;
    localparam logic [4:0] IDX_INT_MASK = 5'h1E;
    localparam logic [4:0] IDX_SPECIAL_CTL = 5'h1F;

    // ------------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------------
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED = 13;
    localparam int CTL_AN_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_AN_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam int STS_AN_COMPLETE = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;
    localparam logic [15:0] STATUS_FIXED_MASK = 16'hFF09;
    localparam logic [15:0] STATUS_FIXED_VALUE = 16'h7809;
    localparam int MODE_SPEED = 0;
    localparam int MODE_DUPLEX = 1;
    localparam int MODE_AN = 2;

    typedef enum logic [4:0] {
        ST_PREAMBLE = 5'h01,
        ST_HEADER = 5'h02,
        ST_TURN = 5'h04,
        ST_RDATA = 5'h08,
        ST_WDATA = 5'h10
    } pbm_state_t;

endpackage : pbm_pkg

// ==== rtl/pbm_mgmt_regs.sv ====
// Serial management slave with the basic control and status registers.
//
// Function
// - Writing control bit 15 starts soft reset; the bit self-clears when done.
// - After soft reset, speed, negotiation and duplex keep register values, not straps.
// - Control bit 14 selects loopback; resets to zero.
// - Control bit 13 selects 100 Mbps; ignored while negotiation is enabled.
// - Control bit 12 enables negotiation, overriding manual speed and duplex.
// - Speed, negotiation enable and duplex reset values come from mode straps.
// - Control bit 10 isolates the device from the data interface.
// - Control bit 9 restarts negotiation and clears itself.
// - Control bit 8 selects full duplex; ignored under negotiation.
// - Control bit 7 enables the collision test; resets to zero.
// - Control bits 6 to 0 are read-only zero; writes do nothing.
// - Status bits 14 to 11 read one, bit 15 reads zero.
// - Status bits 10, 9 and 8 read zero.
// - Status bit 5 shows negotiation complete; resets to zero.
// - Status bit 4 latches high on remote fault until read.
// - Status bits 3 and 0 read one.
// - Status bit 2 shows link, latching low on loss until read.
// - Status bit 1 latches high on jabber until read.
// - Indices 0-6, 16-18, 26, 27, 29-31 are implemented.
// - After a read a latched bit falls, or the link bit rises, only if its condition is gone.
// - Registers are addressed by decimal index over the management link.
module pbm_mgmt_regs
    import pbm_pkg::*;
#(
    parameter logic [15:0] ID_HIGH_RESET = 16'h0A5A, // Value is arbitrary.
    parameter logic [15:0] ID_LOW_RESET = 16'h5A50   // Value is arbitrary.
)
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic [4:0] phy_addr_in,
    input wire logic [2:0] mode_in,
    input wire logic link_up_in,
    input wire logic jabber_in,
    input wire logic remote_fault_in,
    input wire logic an_complete_in,
    input wire logic an_speed_100_in,
    input wire logic an_full_duplex_in,
    output logic soft_reset_out,
    output logic loopback_out,
    output logic speed_100_out,
    output logic full_duplex_out,
    output logic an_enable_out,
    output logic an_restart_out,
    output logic power_down_out,
    output logic isolate_out,
    output logic collision_test_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic rst_s1;
    logic rst_n;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic [4:0] phy_s1;
    logic [4:0] phy_s2;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic mdc_rise;
    pbm_state_t state;
    logic [5:0] ones_cnt;
    logic [4:0] bit_cnt;
    logic [11:0] hdr;
    logic [12:0] header_full;
    logic header_ok;
    logic [4:0] frame_idx;
    logic frame_read;
    logic [15:0] rd_shift;
    logic [15:0] wr_shift;
    logic [15:0] wr_word;
    logic wr_strobe;
    logic rd_take;
    logic rd_status;
    logic ctrl_srst;
    logic ctrl_loop;
    logic ctrl_speed;
    logic ctrl_an;
    logic ctrl_pdown;
    logic ctrl_iso;
    logic ctrl_duplex;
    logic ctrl_col;
    logic an_restart;
    logic [15:0] srst_cnt;
    logic [1:0] strap_wait;
    logic straps_done;
    logic [4:0] phy_addr_q;
    logic jab_lat;
    logic rf_lat;
    logic link_lat;
    logic an_done;
    logic [15:0] ext_regs [0:31];
    logic [15:0] ctrl_word;
    logic [15:0] status_word;
    logic [15:0] read_word;

    localparam int SRST_BOUND = SOFT_RESET_CYCLES + 2;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n);

    function automatic logic is_mapped(input logic [4:0] idx);
        logic hit;
        hit = 1'h0;
        case (idx)
            IDX_CONTROL, IDX_STATUS, IDX_ID_HIGH, IDX_ID_LOW,
            IDX_ADVERTISE, IDX_PARTNER, IDX_EXPANSION,
            IDX_ENERGY_TIMING, IDX_MODE_CTL, IDX_SPECIAL_MODES,
            IDX_SYMBOL_ERR, IDX_SPECIAL_IND, IDX_INT_SOURCE,
            IDX_INT_MASK, IDX_SPECIAL_CTL:
                hit = 1'h1;
            default:
                hit = 1'h0;
        endcase
        return hit;
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_s1 <= 1'h0;
            rst_n <= 1'h0;
        end
        else
        begin
            rst_s1 <= 1'h1;
            rst_n <= rst_s1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_s1 <= 1'h0;
            mdc_s2 <= 1'h0;
            mdc_s3 <= 1'h0;
            mdio_s1 <= 1'h1;
            mdio_s2 <= 1'h1;
            phy_s1 <= 5'h00;
            phy_s2 <= 5'h00;
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
        end
        else
        begin
            mdc_s1 <= mdc_in;
            mdc_s2 <= mdc_s1;
            mdc_s3 <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
            phy_s1 <= phy_addr_in;
            phy_s2 <= phy_s1;
            mode_s1 <= mode_in;
            mode_s2 <= mode_s1;
        end
    end

    assign mdc_rise = mdc_s2 && !mdc_s3;

    // ------------------------------------------------------------------
    // Management frame decoding
    // ------------------------------------------------------------------
    // Preamble suppression is not supported: every frame needs 32 ones.
    assign header_full = {hdr, mdio_s2};
    assign header_ok = header_full[12] &&
        (header_full[9:5] == phy_addr_q) &&
        ((header_full[11:10] == OP_READ) ||
         (header_full[11:10] == OP_WRITE));
    assign rd_take = mdc_rise && (state == ST_HEADER) &&
        (bit_cnt == HEADER_LAST) && header_ok &&
        (header_full[11:10] == OP_READ);
    assign rd_status = rd_take && (header_full[4:0] == IDX_STATUS);
    assign wr_word = {wr_shift[14:0], mdio_s2};
    assign wr_strobe = mdc_rise && (state == ST_WDATA) &&
        (bit_cnt == DATA_LAST);

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_PREAMBLE;
            ones_cnt <= 6'h00;
            bit_cnt <= 5'h00;
            hdr <= 12'h000;
            frame_idx <= 5'h00;
            frame_read <= 1'h0;
            rd_shift <= 16'h0000;
            wr_shift <= 16'h0000;
            mdio_out <= 1'h0;
            mdio_oe_out <= 1'h0;
        end
        else if (mdc_rise)
        begin
            case (state)
                ST_PREAMBLE:
                begin
                    if (mdio_s2)
                    begin
                        if (ones_cnt != PREAMBLE_ONES)
                            ones_cnt <= ones_cnt + 6'h01;
                    end
                    else if (ones_cnt == PREAMBLE_ONES)
                    begin
                        state <= ST_HEADER;
                        bit_cnt <= 5'h00;
                        hdr <= 12'h000;
                    end
                    else
                        ones_cnt <= 6'h00;
                end
                ST_HEADER:
                begin
                    hdr <= header_full[11:0];
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == HEADER_LAST)
                    begin
                        ones_cnt <= 6'h00;
                        bit_cnt <= 5'h00;
                        frame_idx <= header_full[4:0];
                        frame_read <= header_full[11:10] == OP_READ;
                        rd_shift <= read_word;
                        state <= header_ok ? ST_TURN : ST_PREAMBLE;
                    end
                end
                ST_TURN:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h00)
                    begin
                        mdio_oe_out <= frame_read;
                        mdio_out <= 1'h0;
                    end
                    else
                    begin
                        bit_cnt <= 5'h00;
                        state <= frame_read ? ST_RDATA : ST_WDATA;
                        mdio_out <= rd_shift[15];
                        rd_shift <= {rd_shift[14:0], 1'h0};
                    end
                end
                ST_RDATA:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == DATA_LAST)
                    begin
                        mdio_oe_out <= 1'h0;
                        mdio_out <= 1'h0;
                        state <= ST_PREAMBLE;
                    end
                    else
                    begin
                        mdio_out <= rd_shift[15];
                        rd_shift <= {rd_shift[14:0], 1'h0};
                    end
                end
                ST_WDATA:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    wr_shift <= wr_word;
                    if (bit_cnt == DATA_LAST)
                        state <= ST_PREAMBLE;
                end
                default:
                begin
                    state <= ST_PREAMBLE;
                    mdio_oe_out <= 1'h0;
                end
            endcase
        end
    end

    chk_mdio_turn_drive: assert property (
        (state == ST_TURN) && frame_read && mdc_rise &&
        (bit_cnt == 5'h00) |=> mdio_oe_out && !mdio_out)
        else $error("turnaround did not drive zero");

    // ------------------------------------------------------------------
    // Basic control register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_srst <= 1'h0;
            ctrl_loop <= 1'h0;
            ctrl_speed <= 1'h0;
            ctrl_an <= 1'h0;
            ctrl_pdown <= 1'h0;
            ctrl_iso <= 1'h0;
            ctrl_duplex <= 1'h0;
            ctrl_col <= 1'h0;
            an_restart <= 1'h0;
            srst_cnt <= 16'h0000;
            strap_wait <= 2'h0;
            straps_done <= 1'h0;
            phy_addr_q <= 5'h00;
        end
        else
        begin
            an_restart <= 1'h0;
            if (ctrl_srst)
            begin
                // Control register writes arriving during a soft reset are dropped; other mapped registers except status still take theirs.
                if (srst_cnt == 16'h0000)
                    ctrl_srst <= 1'h0;
                else
                    srst_cnt <= srst_cnt - 16'h0001;
            end
            else if (wr_strobe && (frame_idx == IDX_CONTROL))
            begin
                if (wr_word[CTL_SOFT_RESET])
                begin
                    // Speed, negotiation and duplex survive.
                    ctrl_srst <= 1'h1;
                    srst_cnt <= SOFT_RESET_LOAD;
                    ctrl_loop <= 1'h0;
                    ctrl_pdown <= 1'h0;
                    ctrl_iso <= 1'h0;
                    ctrl_col <= 1'h0;
                end
                else
                begin
                    ctrl_loop <= wr_word[CTL_LOOPBACK];
                    ctrl_speed <= wr_word[CTL_SPEED];
                    ctrl_an <= wr_word[CTL_AN_ENABLE];
                    ctrl_pdown <= wr_word[CTL_POWER_DOWN];
                    ctrl_iso <= wr_word[CTL_ISOLATE];
                    ctrl_duplex <= wr_word[CTL_DUPLEX];
                    ctrl_col <= wr_word[CTL_COL_TEST];
                    an_restart <= wr_word[CTL_AN_RESTART];
                end
            end
            if (!straps_done)
            begin
                if (strap_wait == STRAP_WAIT)
                begin
                    ctrl_speed <= mode_s2[MODE_SPEED];
                    ctrl_duplex <= mode_s2[MODE_DUPLEX];
                    ctrl_an <= mode_s2[MODE_AN];
                    phy_addr_q <= phy_s2;
                    straps_done <= 1'h1;
                end
                else
                    strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    chk_srst_selfclear: assert property (
        $rose(ctrl_srst) |-> ##[1:SRST_BOUND] !ctrl_srst)
        else $error("soft reset bit did not clear");

    chk_srst_keeps_cfg: assert property (
        $rose(ctrl_srst) |-> ctrl_an == $past(ctrl_an) &&
        ctrl_speed == $past(ctrl_speed) && !ctrl_loop)
        else $error("soft reset disturbed configuration");

    chk_restart_pulse: assert property (
        an_restart_out |=> !an_restart_out)
        else $error("restart did not self-clear");

    // ------------------------------------------------------------------
    // Latched status indications
    // ------------------------------------------------------------------
    // A read clears a latch only when its condition has gone.
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jab_lat <= 1'h0;
            rf_lat <= 1'h0;
            link_lat <= 1'h0;
            an_done <= 1'h0;
        end
        else
        begin
            jab_lat <= jabber_in ||
                (jab_lat && !rd_status && !ctrl_srst);
            rf_lat <= remote_fault_in ||
                (rf_lat && !rd_status && !ctrl_srst);
            if (rd_status)
                link_lat <= link_up_in;
            else
                link_lat <= link_lat && link_up_in && !ctrl_srst;
            an_done <= an_complete_in;
        end
    end

    chk_jabber_latch: assert property (
        jabber_in |=> jab_lat)
        else $error("jabber not latched");

    chk_fault_hold: assert property (
        rf_lat && !rd_status && !ctrl_srst |=> rf_lat)
        else $error("remote fault dropped without read");

    chk_link_low: assert property (
        !link_up_in ##1 !rd_status |=> !link_lat)
        else $error("link loss not latched low");

    // ------------------------------------------------------------------
    // Other mapped registers and read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 32; i++)
                ext_regs[i] <= 16'h0000;
            ext_regs[IDX_ID_HIGH] <= ID_HIGH_RESET;
            ext_regs[IDX_ID_LOW] <= ID_LOW_RESET;
        end
        else if (wr_strobe && is_mapped(frame_idx) &&
                 (frame_idx != IDX_CONTROL) && (frame_idx != IDX_STATUS))
            ext_regs[frame_idx] <= wr_word;
    end

    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[CTL_SOFT_RESET] = ctrl_srst;
        ctrl_word[CTL_LOOPBACK] = ctrl_loop;
        ctrl_word[CTL_SPEED] = ctrl_speed;
        ctrl_word[CTL_AN_ENABLE] = ctrl_an;
        ctrl_word[CTL_POWER_DOWN] = ctrl_pdown;
        ctrl_word[CTL_ISOLATE] = ctrl_iso;
        ctrl_word[CTL_DUPLEX] = ctrl_duplex;
        ctrl_word[CTL_COL_TEST] = ctrl_col;
        status_word = STATUS_FIXED_VALUE;
        status_word[STS_AN_COMPLETE] = an_done;
        status_word[STS_REMOTE_FAULT] = rf_lat;
        status_word[STS_LINK] = link_lat;
        status_word[STS_JABBER] = jab_lat;
        case (header_full[4:0])
            IDX_CONTROL:
                read_word = ctrl_word;
            IDX_STATUS:
                read_word = status_word;
            default:
                read_word = is_mapped(header_full[4:0]) ?
                    ext_regs[header_full[4:0]] : 16'h0000;
        endcase
    end

    chk_status_fixed: assert property (
        rd_status |=> (rd_shift & STATUS_FIXED_MASK) == STATUS_FIXED_VALUE)
        else $error("status fixed bits wrong");

    chk_ctrl_reserved: assert property (
        rd_take && (header_full[4:0] == IDX_CONTROL) |=>
        rd_shift[6:0] == 7'h00)
        else $error("reserved control bits not zero");

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_reset_out <= 1'h0;
            loopback_out <= 1'h0;
            speed_100_out <= 1'h0;
            full_duplex_out <= 1'h0;
            an_enable_out <= 1'h0;
            an_restart_out <= 1'h0;
            power_down_out <= 1'h0;
            isolate_out <= 1'h0;
            collision_test_out <= 1'h0;
        end
        else
        begin
            soft_reset_out <= ctrl_srst;
            loopback_out <= ctrl_loop;
            // Negotiated results override the manual bits.
            speed_100_out <= ctrl_an ? an_speed_100_in : ctrl_speed;
            full_duplex_out <= ctrl_an ? an_full_duplex_in : ctrl_duplex;
            an_enable_out <= ctrl_an;
            an_restart_out <= an_restart;
            power_down_out <= ctrl_pdown;
            isolate_out <= ctrl_iso;
            collision_test_out <= ctrl_col;
        end
    end

    chk_speed_override: assert property (
        ctrl_an && !ctrl_speed && an_speed_100_in |=> speed_100_out)
        else $error("negotiated speed not applied");

    chk_duplex_manual: assert property (
        !ctrl_an && ctrl_duplex && !an_full_duplex_in |=> full_duplex_out)
        else $error("manual duplex not applied");

endmodule : pbm_mgmt_regs

// ==== bench/pbm_smc.sv ====
// Station management controller model issuing clause 22 frames.
module pbm_smc
(
    input wire logic clk_in,
    input wire logic mdio_in,
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_out = 1'b0;
    end
    // --------------------------------------------------------------
    // Frame driver
    // --------------------------------------------------------------
    // Four clocks per half period, since the slave needs three.
    task automatic bit_io(input logic b, input logic oe, output logic s);
        repeat (4) @(posedge clk_in);
        mdc_out <= 1'b0;
        mdio_out <= b;
        mdio_oe_out <= oe;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        s = mdio_in;
        @(posedge clk_in);
        mdc_out <= 1'b1;
    endtask : bit_io
    task automatic frame(input logic rd, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] q);
        logic [63:0] f;
        logic s;
        f = {32'hFFFFFFFF, 2'h1, rd ? 2'h2 : 2'h1, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--)
        begin
            bit_io(f[i], !(rd && i < 18), s);
            if (i < 16)
                q[i] = s;
        end
        // The pin is released so the pull-up shows between frames.
        bit_io(1'b1, 1'b0, s);
    endtask : frame
endmodule : pbm_smc

// ==== bench/testbench.sv ====
// Self-checking bench for the basic management register bank.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] phy_addr;
    logic [2:0] mode;
    logic link = 1'b1, jab = 1'b0, rfault = 1'b0, an_done = 1'b0;
    logic an_spd, an_fd, mdc, h_do, h_oe, d_do, d_oe;
    logic sr, lb, spd, fd, an_en, an_rs, pd, iso, col;
    logic [15:0] rd, w;
    wire mdio = d_oe ? d_do : (h_oe ? h_do : 1'b1);
    int seed = 32'h0d8daf59;
    int miscompares = 0, compares = 0, cycles = 0, restarts = 0, ctl, r0;
    int idx[$] = '{2, 3, 4, 5, 6, 16, 17, 18, 26, 27, 29, 30, 31};
    int vals[13];
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    pbm_mgmt_regs dut (.ref_clk_in(ref_clk), .resetn_in(resetn),
        .mdc_in(mdc), .mdio_in(mdio), .mdio_out(d_do), .mdio_oe_out(d_oe),
        .phy_addr_in(phy_addr), .mode_in(mode), .link_up_in(link),
        .jabber_in(jab), .remote_fault_in(rfault), .an_complete_in(an_done),
        .an_speed_100_in(an_spd), .an_full_duplex_in(an_fd),
        .soft_reset_out(sr), .loopback_out(lb), .speed_100_out(spd),
        .full_duplex_out(fd), .an_enable_out(an_en), .an_restart_out(an_rs),
        .power_down_out(pd), .isolate_out(iso), .collision_test_out(col));
    pbm_smc smc (.clk_in(ref_clk), .mdio_in(mdio), .mdc_out(mdc),
        .mdio_out(h_do), .mdio_oe_out(h_oe));
    // --------------------------------------------------------------
    // Checking and access tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        smc.frame(1'b0, phy_addr, ra, d, rd);
    endtask : wr
    task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
        smc.frame(1'b1, phy_addr, ra, 16'h0000, rd);
        chk(rd, e);
    endtask : rdc
    task automatic wrap_up();
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (an_rs === 1'b1)
            restarts <= restarts + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    initial
    begin
        phy_addr <= 5'($random(seed));
        mode <= 3'($random(seed));
        {an_spd, an_fd} <= 2'($random(seed));
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        ctl = {mode[0], mode[2], 3'h0, mode[1], 8'h00};
        rdc(5'h00, 16'(ctl));
        {link, jab, rfault, an_done} <= 4'h7;
        @(posedge ref_clk);
        {link, jab} <= 2'h2;
        repeat (4) @(posedge ref_clk);
        rdc(5'h01, 16'h783B);
        rdc(5'h01, 16'h783D);
        rfault <= 1'b0;
        rdc(5'h01, 16'h783D);
        wr(5'h01, 16'h0000);
        rdc(5'h01, 16'h782D);
        for (int i = 0; i < 4; i++)
        begin
            {an_spd, an_fd} <= 2'($random(seed));
            w = 16'($random(seed)) & 16'h7D80;
            w[12] = i[1];
            if (w[12] || ctl[12])
                w[11] = 1'b0;
            wr(5'h00, w);
            ctl = w & 16'h7D80;
            rdc(5'h00, 16'(ctl));
            chk(16'({lb, pd, iso, col, an_en}),
                16'({w[14], w[11], w[10], w[7], w[12]}));
            chk(16'({spd, fd}), 16'(w[12] ? {an_spd, an_fd} :
                {w[13], w[8]}));
        end
        r0 = restarts;
        wr(5'h00, 16'(ctl | 16'h0200));
        rdc(5'h00, 16'(ctl));
        chk(16'(restarts - r0), 16'h0001);
        wr(5'h00, 16'h8000);
        ctl = ctl & 16'h3100;
        rdc(5'h00, 16'(ctl));
        chk(16'({sr, lb, pd, iso, col}), 16'h0000);
        foreach (idx[k])
        begin
            vals[k] = $random(seed);
            wr(5'(idx[k]), 16'(vals[k]));
        end
        foreach (idx[k])
            rdc(5'(idx[k]), 16'(vals[k]));
        wr(5'h07, 16'hFFFF);
        rdc(5'h07, 16'h0000);
        smc.frame(1'b0, phy_addr ^ 5'h01, 5'h00, 16'h4000, rd);
        rdc(5'h00, 16'(ctl));
        wrap_up();
    end
endmodule : testbench
